// [adc_diag_config_registers_bench.sv]
// adc_diag_config_registers_bench: self-checking bench for adcdg_regs
`timescale 1ns/1ps
module adc_diag_config_registers_bench;
   localparam int SDIV = 4;
   localparam int ODIV = 5;
   localparam logic [3:0] PC = 4'ha; // arbitrary value
   localparam logic [3:0] SR = 4'h2; // arbitrary value
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, v, c0;
   logic [1:0] htrans;
   logic [2:0] hsize, ch7_source_select, ch8_source_select;
   logic ch7_force_10v_range, ch8_force_10v_range;
   logic open_detect_manual, open_detect_auto;
   logic [7:0] open_detect_queue_count, q;
   int fails, n_checks;
   assign hready = hreadyout;

   adcdg_regs #(.PART_CODE(PC), .SILICON_REV(SR), .SAMPLE_DIV(SDIV),
      .OVERSAMPLE_DIV(ODIV)) adcdg_regs_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ch7_source_select(ch7_source_select),
      .ch8_source_select(ch8_source_select),
      .ch7_force_10v_range(ch7_force_10v_range),
      .ch8_force_10v_range(ch8_force_10v_range),
      .open_detect_manual(open_detect_manual),
      .open_detect_auto(open_detect_auto),
      .open_detect_queue_count(open_detect_queue_count));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] adr(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction : adr

   // expected flags: force7, force8, manual, auto
   function automatic logic [3:0] flags(input logic [7:0] d,
      input logic [7:0] qd);
      return {d[2:0] != 3'h0, d[5:3] != 3'h0, qd == 8'h01, qd > 8'h01};
   endfunction : flags

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one single transfer; the slave answer is awaited, never assumed
   task automatic xfer(input logic [31:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      #1;
   endtask : xfer

   task automatic outs(input logic [7:0] d, input logic [7:0] qd);
      chk({26'h0, ch8_source_select, ch7_source_select}, {26'h0, d[5:0]});
      chk({28'h0, ch7_force_10v_range, ch8_force_10v_range,
         open_detect_manual, open_detect_auto}, {28'h0, flags(d, qd)});
      chk({24'h0, open_detect_queue_count}, {24'h0, qd});
   endtask : outs

   task automatic tally_and_finish;
      if (fails == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // -----------------------------------------------------------------
   // clock, watchdog and tests
   // -----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      tally_and_finish;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fails = 0;
      n_checks = 0;
      v = $urandom(32'hec729315);
      repeat (3) @(posedge hclk);
      chk({31'h0, hreadyout}, 32'h0);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      // reset values, id, unmapped read
      xfer(adr(8'h2b), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      xfer(adr(8'h2c), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      xfer(adr(8'h2f), 1'b0, 32'h0, rd);
      chk(rd, {24'h0, PC, SR});
      xfer(adr(8'h30), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      outs(8'h00, 8'h00);
      // every source code on both channels, reserved bits set at random
      for (int i = 0; i < 16; i++) begin
         v = $urandom;
         v[2:0] = i[2:0];
         if (i < 8) v[5:3] = ~i[2:0];
         xfer(adr(8'h2b), 1'b1, v, rd);
         xfer(adr(8'h2b), 1'b0, 32'h0, rd);
         chk(rd, {26'h0, v[5:0]});
         outs(v[7:0], 8'h00);
      end
      // queue modes: off, manual, smallest and largest auto, random
      for (int i = 0; i < 8; i++) begin
         q = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h02 :
            (i == 3) ? 8'hff : 8'($urandom);
         xfer(adr(8'h2c), 1'b1, {24'($urandom), q}, rd);
         xfer(adr(8'h2c), 1'b0, 32'h0, rd);
         chk(rd, {24'h0, q});
         outs(v[7:0], q);
      end
      // writes to read-only and unmapped places change nothing
      for (int i = 8'h2d; i <= 8'h30; i++) begin
         xfer(adr(8'(i)), 1'b1, 32'hffff_ffff, rd);
      end
      xfer(adr(8'h2f), 1'b0, 32'h0, rd);
      chk(rd, {24'h0, PC, SR});
      outs(v[7:0], q);
      // monitor counters: equal spacing of reads, 300 steps wrap to 44
      xfer(adr(8'h2d), 1'b0, 32'h0, c0);
      // two address edges are SDIV * 300 cycles apart: wait plus two
      repeat (SDIV * 300 - 2) @(posedge hclk);
      xfer(adr(8'h2d), 1'b0, 32'h0, rd);
      chk(rd, {24'h0, c0[7:0] + 8'd44});
      xfer(adr(8'h2e), 1'b0, 32'h0, c0);
      repeat (ODIV * 300 - 2) @(posedge hclk);
      xfer(adr(8'h2e), 1'b0, 32'h0, rd);
      chk(rd, {24'h0, c0[7:0] + 8'd44});
      // second reset in mid-run clears the settings
      @(posedge hclk);
      hresetn <= 1'b0;
      #1;
      outs(8'h00, 8'h00);
      chk({31'h0, hreadyout}, 32'h0);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      xfer(adr(8'h2b), 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      tally_and_finish;
   end
endmodule : adc_diag_config_registers_bench

// [adcdg_pkg.sv]
// adcdg_pkg: shared constants for the diagnostic and configuration registers
package adcdg_pkg;

   // -----------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_DIAG_SOURCE_SELECT_CH7_CH8 = 8'h2b;
   localparam logic [7:0] IDX_OPEN_CIRCUIT_QUEUE_DEPTH = 8'h2c;
   localparam logic [7:0] IDX_SAMPLE_CLOCK_MONITOR_COUNT = 8'h2d;
   localparam logic [7:0] IDX_OVERSAMPLE_CLOCK_MONITOR_COUNT = 8'h2e;
   localparam logic [7:0] IDX_PART_IDENTIFICATION = 8'h2f;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CH8_SEL_LSB = 3;
   localparam int CH8_SEL_MSB = 5;
   localparam int CH7_SEL_LSB = 0;
   localparam int CH7_SEL_MSB = 2;
   localparam int PART_CODE_LSB = 4;
   localparam int PART_CODE_MSB = 7;
   localparam int SILICON_REV_LSB = 0;
   localparam int SILICON_REV_MSB = 3;

   // -----------------------------------------------------------------
   // reset values and encodings
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_DIAG_SOURCE_SELECT = 8'h00;
   localparam logic [7:0] RST_OPEN_CIRCUIT_QUEUE = 8'h00;
   localparam logic [7:0] RST_CLOCK_MONITOR_COUNT = 8'h00;
   localparam logic [2:0] SRC_ANALOG_PIN = 3'h0;
   localparam logic [7:0] QUEUE_MANUAL = 8'h01;

   // -----------------------------------------------------------------
   // timing: monitored rates in kHz, each counter steps at rate / 64
   // -----------------------------------------------------------------
   localparam int HCLK_KHZ = 125000;
   localparam int SAMPLE_CLOCK_KHZ = 16000;
   localparam int OVERSAMPLE_CLOCK_KHZ = 12500;
   localparam int MONITOR_PRESCALE = 64;
   localparam int SAMPLE_TICK_CYCLES =
      HCLK_KHZ * MONITOR_PRESCALE / SAMPLE_CLOCK_KHZ;
   localparam int OVERSAMPLE_TICK_CYCLES =
      HCLK_KHZ * MONITOR_PRESCALE / OVERSAMPLE_CLOCK_KHZ;

endpackage : adcdg_pkg

// [adcdg_rate_counter.sv]
// adcdg_rate_counter: divider plus free-running 8-bit monitor counter
`timescale 1ns/1ps
module adcdg_rate_counter #(
   parameter int DIV_CYCLES = 500
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // counter value
   output logic [7:0] count
);

   typedef struct packed {
      logic [15:0] div;
      logic tick;
      logic [7:0] count;
   } adcdg_rc_state_type;

   adcdg_rc_state_type st;
   adcdg_rc_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.div == 16'(DIV_CYCLES - 1)) begin
         next_st.div = 16'h0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.div = st.div + 16'h0001;
      end
      // wraps at 8 bits so software compares readings modulo 256
      if (st.tick) begin
         next_st.count = st.count + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_count_step;
      @(posedge hclk) disable iff (!hresetn)
      st.tick |=> (st.count == $past(st.count) + 8'h01) && !st.tick;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("monitor counter did not step once per tick");

   // between ticks the counter must hold, or readings would drift
   property p_count_hold;
      @(posedge hclk) disable iff (!hresetn)
      !st.tick |=> (st.count == $past(st.count));
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("monitor counter moved without a tick");

endmodule : adcdg_rate_counter

// [adcdg_regs.sv]
// adcdg_regs: diagnostic source, open-detect queue, clock monitors, id
// Contract
// - ch8 source field bits 5:3 picks analog pin or internal source.
// - ch7 source field bits 2:0, same encoding; internal source uses 10 V.
// - queue value 1 selects manual open-circuit detection.
// - queue above 1 selects automatic detection after that many conversions.
// - 8-bit read-only counter steps at 16 MHz divided by 64.
// - second 8-bit read-only counter steps at 12.5 MHz divided by 64.
// - id register: part code bits 7:4, revision bits 3:0, writes ignored.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adcdg_regs #(
   parameter logic [3:0] PART_CODE = 4'ha, // arbitrary value
   parameter logic [3:0] SILICON_REV = 4'h2, // arbitrary value
   parameter int SAMPLE_DIV = adcdg_pkg::SAMPLE_TICK_CYCLES,
   parameter int OVERSAMPLE_DIV = adcdg_pkg::OVERSAMPLE_TICK_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // diagnostic routing to the channel front ends
   output logic [2:0] ch7_source_select,
   output logic [2:0] ch8_source_select,
   output logic ch7_force_10v_range,
   output logic ch8_force_10v_range,
   // open-circuit detection setup
   output logic open_detect_manual,
   output logic open_detect_auto,
   output logic [7:0] open_detect_queue_count
);

   typedef struct packed {
      logic ready;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic [2:0] ch7;
      logic [2:0] ch8;
      logic ch7_10v;
      logic ch8_10v;
      logic [7:0] queue;
      logic manual;
      logic auto_mode;
   } adcdg_state_type;

   adcdg_state_type st;
   adcdg_state_type next_st;
   logic [7:0] fs_count;
   logic [7:0] os_count;
   logic addr_phase;
   logic [7:0] ap_idx;
   logic ap_in_range;

   // -----------------------------------------------------------------
   // clock monitor counters
   // -----------------------------------------------------------------
   adcdg_rate_counter #(.DIV_CYCLES(SAMPLE_DIV)) u_fs_mon (
      .hclk(hclk),
      .hresetn(hresetn),
      .count(fs_count)
   );

   adcdg_rate_counter #(.DIV_CYCLES(OVERSAMPLE_DIV)) u_os_mon (
      .hclk(hclk),
      .hresetn(hresetn),
      .count(os_count)
   );

   // -----------------------------------------------------------------
   // bus decode and register update
   // -----------------------------------------------------------------
   assign addr_phase = hsel & htrans[1] & hready;
   assign ap_idx = haddr[9:2];
   assign ap_in_range = (haddr[31:10] == 22'h000000) &&
                        (haddr[1:0] == 2'h0);

   always_comb begin
      next_st = st;
      next_st.ready = 1'b1;
      // data phase of a write: hwdata stands now
      if (st.wr_pend) begin
         next_st.wr_pend = 1'b0;
         case (st.wr_idx)
            adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8: begin
               // bits 7:6 are not stored
               next_st.ch8 = hwdata[adcdg_pkg::CH8_SEL_MSB:
                                    adcdg_pkg::CH8_SEL_LSB];
               next_st.ch7 = hwdata[adcdg_pkg::CH7_SEL_MSB:
                                    adcdg_pkg::CH7_SEL_LSB];
            end
            adcdg_pkg::IDX_OPEN_CIRCUIT_QUEUE_DEPTH: begin
               next_st.queue = hwdata[7:0];
            end
            // counters and id are read-only; other writes are dropped
            default: begin
               next_st.queue = st.queue;
            end
         endcase
      end
      next_st.ch7_10v = (next_st.ch7 != adcdg_pkg::SRC_ANALOG_PIN);
      next_st.ch8_10v = (next_st.ch8 != adcdg_pkg::SRC_ANALOG_PIN);
      next_st.manual = (next_st.queue == adcdg_pkg::QUEUE_MANUAL);
      next_st.auto_mode = (next_st.queue > adcdg_pkg::QUEUE_MANUAL);
      // read data is taken from the next values so a read straight after
      // a write sees the written value
      if (addr_phase) begin
         next_st.wr_pend = hwrite & ap_in_range;
         next_st.wr_idx = ap_idx;
         next_st.rdata = 32'h00000000;
         if (!hwrite && ap_in_range) begin
            case (ap_idx)
               adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8: begin
                  next_st.rdata[7:0] = {2'h0, next_st.ch8,
                                        next_st.ch7};
               end
               adcdg_pkg::IDX_OPEN_CIRCUIT_QUEUE_DEPTH: begin
                  next_st.rdata[7:0] = next_st.queue;
               end
               adcdg_pkg::IDX_SAMPLE_CLOCK_MONITOR_COUNT: begin
                  next_st.rdata[7:0] = fs_count;
               end
               adcdg_pkg::IDX_OVERSAMPLE_CLOCK_MONITOR_COUNT: begin
                  next_st.rdata[7:0] = os_count;
               end
               adcdg_pkg::IDX_PART_IDENTIFICATION: begin
                  next_st.rdata[7:0] = {PART_CODE, SILICON_REV};
               end
               default: begin
                  next_st.rdata = 32'h00000000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign hreadyout = st.ready;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign ch7_source_select = st.ch7;
   assign ch8_source_select = st.ch8;
   assign ch7_force_10v_range = st.ch7_10v;
   assign ch8_force_10v_range = st.ch8_10v;
   assign open_detect_manual = st.manual;
   assign open_detect_auto = st.auto_mode;
   assign open_detect_queue_count = st.queue;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_ch8_write;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8)
      |=> ch8_source_select == $past(hwdata[5:3]);
   endproperty
   a_ch8_write: assert property (p_ch8_write)
      else $error("ch8 source select not taken from write data");

   property p_ch8_range;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8)
      |=> ch8_force_10v_range == ($past(hwdata[5:3]) != 3'h0);
   endproperty
   a_ch8_range: assert property (p_ch8_range)
      else $error("ch8 range force does not follow source select");

   property p_ch7_range;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8)
      |=> ch7_force_10v_range == ($past(hwdata[2:0]) != 3'h0);
   endproperty
   a_ch7_range: assert property (p_ch7_range)
      else $error("ch7 range force does not follow source select");

   property p_manual;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == adcdg_pkg::IDX_OPEN_CIRCUIT_QUEUE_DEPTH &&
       hwdata[7:0] == 8'h01) |=> open_detect_manual && !open_detect_auto;
   endproperty
   a_manual: assert property (p_manual)
      else $error("queue value 1 did not select manual detection");

   property p_auto;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend && st.wr_idx == adcdg_pkg::IDX_OPEN_CIRCUIT_QUEUE_DEPTH &&
       hwdata[7:0] > 8'h01) |=> open_detect_auto && !open_detect_manual &&
      open_detect_queue_count == $past(hwdata[7:0]);
   endproperty
   a_auto: assert property (p_auto)
      else $error("queue above 1 did not select automatic detection");

   property p_os_read;
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && ap_in_range &&
       ap_idx == adcdg_pkg::IDX_OVERSAMPLE_CLOCK_MONITOR_COUNT)
      |=> hrdata == {24'h000000, $past(os_count)};
   endproperty
   a_os_read: assert property (p_os_read)
      else $error("oversample monitor read returned wrong value");

   property p_fs_read;
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && ap_in_range &&
       ap_idx == adcdg_pkg::IDX_SAMPLE_CLOCK_MONITOR_COUNT)
      |=> hrdata == {24'h000000, $past(fs_count)};
   endproperty
   a_fs_read: assert property (p_fs_read)
      else $error("sample monitor read returned wrong value");

   // a write to a read-only or unmapped place must leave all settings alone
   property p_ro_write;
      @(posedge hclk) disable iff (!hresetn)
      (st.wr_pend &&
       st.wr_idx != adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8 &&
       st.wr_idx != adcdg_pkg::IDX_OPEN_CIRCUIT_QUEUE_DEPTH)
      |=> $stable(open_detect_queue_count) && $stable(ch7_source_select) &&
      $stable(ch8_source_select);
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write to read-only register changed a setting");

   property p_mode_off;
      @(posedge hclk) disable iff (!hresetn)
      (open_detect_queue_count == 8'h00)
      |-> !open_detect_manual && !open_detect_auto;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("queue value 0 selected a detection mode");

   property p_id_read;
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && ap_in_range &&
       ap_idx == adcdg_pkg::IDX_PART_IDENTIFICATION)
      |=> hrdata == {24'h000000, PART_CODE, SILICON_REV};
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("id register read returned wrong value");

   property p_reserved;
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && ap_in_range &&
       ap_idx == adcdg_pkg::IDX_DIAG_SOURCE_SELECT_CH7_CH8)
      |=> hrdata[7:6] == 2'h0 && hrdata[5:0] == {ch8_source_select,
                                                  ch7_source_select};
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("ch7/ch8 register reserved bits not zero");

endmodule : adcdg_regs
